/* File: rtl/nvb_host.sv */
`timescale 1ns/100ps
`include "nvb_params.svh"
module nvb_host
	import nvb_pkg::*;
#(
	parameter int ADDR_W = `NVB_ADDR_W,
	parameter int DATA_W = `NVB_DATA_W
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// User request
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqData,
	output logic reqReady,
	// User answer
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	// Memory pins
	output logic [ADDR_W-1:0] memAddr,
	output logic chipEnable_n,
	output logic outputEnable_n,
	output logic writeEnable_n,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe
);
	// Cycle counts, least times rounded up
	function automatic logic [`NVB_CNT_W-1:0] nsToCycles(input int ns);
		int c;
		c = (ns + `NVB_CLK_PERIOD_NS - 1) / `NVB_CLK_PERIOD_NS;
		if (c < 1)
			c = 1;
		return c[`NVB_CNT_W-1:0];
	endfunction : nsToCycles

	// Last cycle of a phase, shared by the pin processes
	function automatic logic phaseEnd(input nvb_state_t cur,
		input nvb_state_t phase, input logic expired);
		return (cur == phase) && expired;
	endfunction : phaseEnd

	localparam logic [`NVB_CNT_W-1:0] ACCESS_CYC = nsToCycles(`NVB_ACCESS_NS);
	localparam logic [`NVB_CNT_W-1:0] PRE_CYC =
		nsToCycles(`NVB_MIN_PRECHARGE_NS);
	localparam logic [`NVB_CNT_W-1:0] HOLD_CYC =
		nsToCycles(`NVB_ADDR_HOLD_NS);
	localparam logic [`NVB_CNT_W-1:0] LOW_CYC =
		nsToCycles(`NVB_CYCLE_NS - `NVB_MIN_PRECHARGE_NS);
	// Low time never shorter than the access
	localparam logic [`NVB_CNT_W-1:0] LOW_LOAD =
		(ACCESS_CYC > LOW_CYC) ? ACCESS_CYC : LOW_CYC;

	nvb_state_t state;
	logic isWrite;
	logic timerLoad;
	logic [`NVB_CNT_W-1:0] timerValue;
	logic timerDone;

	nvb_timer #(.CNT_W(`NVB_CNT_W)) uTimer
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(timerLoad),
		.loadValue(timerValue),
		.done(timerDone)
	);

	logic accessEnd;
	logic prechargeEnd;
	assign accessEnd = phaseEnd(state, NVB_ACTIVE, timerDone);
	assign prechargeEnd = phaseEnd(state, NVB_PRECHARGE, timerDone);

	// Timer loads at each phase entry
	always_comb
	begin
		timerLoad = 1'b0;
		timerValue = '0;
		case (state)
			NVB_IDLE:
			begin
				timerLoad = reqValid;
				timerValue = HOLD_CYC;
			end
			NVB_SETUP:
			begin
				timerLoad = 1'b1;
				timerValue = LOW_LOAD;
			end
			NVB_ACTIVE:
			begin
				timerLoad = timerDone;
				timerValue = PRE_CYC;
			end
			default:
			begin
				timerLoad = 1'b0;
				timerValue = '0;
			end
		endcase
	end

	// Sequencer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state <= NVB_IDLE;
		else
			case (state)
				NVB_IDLE:
					if (reqValid)
						state <= NVB_SETUP;
				NVB_SETUP:
					state <= NVB_ACTIVE;
				NVB_ACTIVE:
					if (timerDone)
						state <= NVB_PRECHARGE;
				NVB_PRECHARGE:
					// RQ17 precharge high time
					if (timerDone)
						state <= NVB_IDLE;
				default:
					state <= NVB_IDLE;
			endcase
	end

	// Address and write data held from request to precharge
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memAddr <= '0;
			dataOut <= '0;
			isWrite <= 1'b0;
		end
		else if (state == NVB_IDLE && reqValid)
		begin
			// RQ1 address before fall
			memAddr <= reqAddr;
			// RQ13 data stable early
			dataOut <= reqData;
			isWrite <= reqWrite;
		end
	end

	// Chip select: one fresh fall per access, bounded low time
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			chipEnable_n <= 1'b1;
		// RQ7 fresh falling edge
		else if (state == NVB_SETUP)
			chipEnable_n <= 1'b0;
		// RQ18 bounded low time
		else if (accessEnd)
			chipEnable_n <= 1'b1;
	end

	// Write enable low at the same edge as the fall avoids bus contention
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			writeEnable_n <= 1'b1;
			outputEnable_n <= 1'b1;
			dataOe <= 1'b0;
		end
		else if (state == NVB_SETUP)
		begin
			// RQ11 chip-select controlled write
			writeEnable_n <= !isWrite;
			outputEnable_n <= isWrite;
			// RQ3 drive bus on writes
			dataOe <= isWrite;
		end
		else if (accessEnd)
		begin
			// RQ13 write ends together
			writeEnable_n <= 1'b1;
			outputEnable_n <= 1'b1;
		end
		else if (state == NVB_PRECHARGE)
			dataOe <= 1'b0;
	end

	// Read capture after the full access time
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rspValid <= 1'b0;
			rspData <= '0;
		end
		// RQ9 sample after access
		else if (accessEnd && !isWrite)
		begin
			rspValid <= 1'b1;
			rspData <= dataIn;
		end
		// RQ15 writes answer at access end, same edge as reads
		else if (accessEnd && isWrite)
			rspValid <= 1'b1;
		else
			rspValid <= 1'b0;
	end

	// Ready only in idle; one request per cycle of the memory
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			reqReady <= 1'b0;
		// RQ14 single timing path
		else
			reqReady <= prechargeEnd ||
				(state == NVB_IDLE && !reqValid);
	end
endmodule : nvb_host

/* File: rtl/nvb_params.svh */
// Functional notes
// RQ1 - Memory holds 32,768 bytes picked by a 15-bit address latched at chip-select fall.
// RQ2 - Address changes while chip select stays low are ignored by the memory.
// RQ3 - Bytes move both ways over one 8-bit bidirectional data bus.
// RQ4 - Write enable low stores the bus byte at the latched address.
// RQ5 - Write enable already low at chip-select fall starts the cycle as a write.
// RQ6 - Output enable only gates the memory's data drivers.
// RQ7 - Host makes a fresh chip-select falling edge for every access.
// RQ8 - Memory finishes its internal cycle even if chip select rises early.
// RQ9 - Read data is valid only 70 ns after chip select falls.
// RQ10 - Early output enable leaves the bus undriven until data is valid.
// RQ11 - Chip-select-controlled write: memory never drives the data bus.
// RQ12 - Write enable falling late starts as a read, driven per output enable.
// RQ13 - Write ends at first rising edge; host holds data stable before it.
// RQ14 - Read and write share 130 ns cycle time and one access time.
// RQ15 - Writes finish within their cycle; next access may follow at once.
// RQ16 - Precharge begins only when chip select rises.
// RQ17 - Host keeps chip select high for at least the minimum precharge time.
// RQ18 - Host keeps every chip-select low time below the allowed maximum.
// RQ19 - Address changes after latch and hold have no effect on the operation.
// RQ20 - A read returns the last byte written there; contents persist unpowered.
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH
`define NVB_CLK_PERIOD_NS 10
`define NVB_ACCESS_NS 70
`define NVB_CYCLE_NS 130
`define NVB_MIN_PRECHARGE_NS 60
`define NVB_ADDR_HOLD_NS 10
`define NVB_DATA_SETUP_NS 30
`define NVB_ADDR_W 15
`define NVB_DATA_W 8
`define NVB_CNT_W 8
`endif

/* File: rtl/nvb_pkg.sv */
package nvb_pkg;
	typedef enum logic [2:0]
	{
		NVB_IDLE = 3'b000,
		NVB_SETUP = 3'b001,
		NVB_ACTIVE = 3'b010,
		NVB_PRECHARGE = 3'b011
	} nvb_state_t;
endpackage : nvb_pkg

/* File: rtl/nvb_timer.sv */
`timescale 1ns/100ps
`include "nvb_params.svh"
module nvb_timer
	import nvb_pkg::*;
#(
	parameter int CNT_W = `NVB_CNT_W
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic load,
	input wire logic [CNT_W-1:0] loadValue,
	output logic done
);
	logic [CNT_W-1:0] count;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			count <= '0;
		else if (load)
			count <= loadValue;
		else if (count != '0)
			count <= count - 1'b1;
	end

	// No load term: a load fed back from done would close a loop
	assign done = (count == '0);
endmodule : nvb_timer

/* File: testbench/nvb_host_asserts.sv */
`timescale 1ns/100ps
module nvb_host_asserts
(
	// Clock
	input wire logic clk_sys,
	input wire logic rst_n,
	// Pins
	input wire logic rspValid,
	input wire logic reqReady,
	input wire logic [14:0] memAddr,
	input wire logic chipEnable_n,
	input wire logic outputEnable_n,
	input wire logic writeEnable_n,
	input wire logic [7:0] dataOut,
	input wire logic dataOe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_addr_held: assert property (!chipEnable_n |-> $stable(memAddr))
		else $error("address moved");
	a_ce_low: assert property ($fell(chipEnable_n) |->
		!chipEnable_n [*8] ##1 chipEnable_n)
		else $error("bad select time");
	a_precharge: assert property ($rose(chipEnable_n) |-> chipEnable_n [*6])
		else $error("short precharge");
	a_we_early: assert property ($fell(writeEnable_n) |-> $fell(chipEnable_n))
		else $error("write start");
	a_we_end: assert property ($rose(writeEnable_n) |-> $rose(chipEnable_n))
		else $error("write end");
	a_drive_write: assert property (dataOe |->
		!writeEnable_n || $rose(writeEnable_n))
		else $error("drive outside write");
	a_data_stable: assert property (!writeEnable_n && !$past(writeEnable_n)
		|-> dataOe && $stable(dataOut))
		else $error("write data moved");
	a_rsp_end: assert property (rspValid == $rose(chipEnable_n))
		else $error("answer timing");
	a_oe_write: assert property (!writeEnable_n |-> outputEnable_n)
		else $error("read enable in write");
	a_ready_idle: assert property (reqReady |-> chipEnable_n)
		else $error("ready while selected");
	c_write: cover property ($fell(writeEnable_n));
	c_ready: cover property (reqReady);
	c_read: cover property ($fell(chipEnable_n) && writeEnable_n);
	c_resp: cover property (rspValid);
endmodule : nvb_host_asserts
bind nvb_host nvb_host_asserts chk_u (.clk_sys, .rst_n, .rspValid, .reqReady,
	.memAddr, .chipEnable_n, .outputEnable_n, .writeEnable_n, .dataOut,
	.dataOe);

/* File: testbench/nvb_mem_model.sv */
`timescale 1ns/100ps
module nvb_mem_model
(
	// Pins
	input wire logic ceN,
	input wire logic oeN,
	input wire logic weN,
	input wire logic [14:0] addr,
	input wire logic [7:0] bus,
	// Drive
	output logic drive,
	output logic [7:0] rdData
);
	logic [7:0] mem [0:32767];
	logic [14:0] lat = 15'h0000;
	logic wrAct = 1'b0;
	logic valid = 1'b0;
	always @(negedge ceN)
	begin
		lat = addr;
		wrAct = !weN;
		valid <= #69.9 1'b1;
	end
	always @(negedge weN)
		if (!ceN)
			wrAct = 1'b1;
	always @(posedge ceN or posedge weN)
	begin
		if (wrAct)
			mem[lat] = bus;
		wrAct = 1'b0;
		valid = 1'b0;
	end
	assign drive = !ceN && !oeN && valid && !wrAct;
	assign rdData = mem[lat];
endmodule : nvb_mem_model

/* File: testbench/test_bytewide_nvram_bus_port.sv */
`timescale 1ns/100ps
module test_bytewide_nvram_bus_port;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	logic reqWrite = 1'b0;
	logic [14:0] reqAddr = 15'h0000;
	logic [7:0] reqData = 8'h00;
	logic reqReady, rspValid, chipEnable_n, outputEnable_n, writeEnable_n;
	logic dataOe, memDrive;
	logic [7:0] rspData, dataOut, memRd;
	logic [7:0] noise = 8'h00;
	logic [14:0] memAddr;
	wire logic [7:0] dataIn;
	logic [8:0] notes [$];
	logic [8:0] note;
	logic [7:0] refMem [0:32767];
	logic [14:0] used [0:23];
	int seed = 8082;
	int fails = 0;
	int n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	// Undriven bus wanders
	always @(posedge clk_sys) noise <= noise + 8'h3B;
	assign dataIn = dataOe ? dataOut : (memDrive ? memRd : noise);
	nvb_host dut_u (.clk_sys, .rst_n, .reqValid, .reqWrite, .reqAddr, .reqData,
		.reqReady, .rspValid, .rspData, .memAddr, .chipEnable_n,
		.outputEnable_n, .writeEnable_n, .dataIn, .dataOut, .dataOe);
	nvb_mem_model mem_u (.ceN(chipEnable_n), .oeN(outputEnable_n),
		.weN(writeEnable_n), .addr(memAddr), .bus(dataIn), .drive(memDrive),
		.rdData(memRd));
	task check_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_byte
	task give_verdict();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task access(input logic wr, input logic [14:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reqValid = 1'b1;
		reqWrite = wr;
		reqAddr = a;
		reqData = d;
		if (wr)
			refMem[a] = d;
		notes.push_back({wr, refMem[a]});
		repeat (40)
		begin
			@(posedge clk_sys);
			#1;
			if (rspValid === 1'b1)
				break;
		end
		reqValid = 1'b0;
	endtask : access
	always @(negedge clk_sys)
		if (rspValid === 1'b1 && notes.size() > 0)
		begin
			note = notes.pop_front();
			if (!note[8]) check_byte(rspData, note[7:0]);
		end
		else if (rspValid === 1'b1)
			check_byte(8'h01, 8'h00);
	// Host and memory never drive together
	always @(negedge clk_sys)
		if (memDrive === 1'b1)
			check_byte({7'h00, dataOe}, 8'h00);
	initial
	begin
		repeat (20) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		access(1'b1, 15'h7FFF, 8'hA5);
		access(1'b1, 15'h0000, 8'h5A);
		access(1'b0, 15'h7FFF, 8'h00);
		access(1'b0, 15'h0000, 8'h00);
		// Write then read back, each access polls for its answer
		for (int i = 0; i < 24; i++)
		begin
			used[i] = 15'($random(seed));
			access(1'b1, used[i], 8'($random(seed)));
			access(1'b0, used[i], 8'h00);
		end
		for (int i = 0; i < 24; i++)
			access(1'b0, used[i], 8'h00);
		repeat (4) @(posedge clk_sys);
		check_byte(8'(notes.size()), 8'h00);
		give_verdict();
	end
	// Run needs about 13 us
	initial
	begin
		#50000;
		fails++;
		give_verdict();
	end
endmodule : test_bytewide_nvram_bus_port
